// *** hdl/dsrc_pkg.sv ***
// drive restart and stop control: shared constants, types and states
// assumes settings come from a parameter store on the same clock
//
// Overview of operation
// [RULE1] cycle mode 4..6: run after a stop restarts step sequence at step one
// [RULE2] cycle mode 1..3: run after a stop continues the unfinished step
// [RULE3] ride-through off: loss over 8 ms trips undervoltage; on: resume
// [RULE4] restart interval is reset time if above inhibit time, else inhibit
// [RULE5] fault: output off, fault shown, runs refused during inhibit time
// [RULE6] after inhibit time the fault clears, then a speed search follows
// [RULE7] attempts counted against limit 0..10; beyond it output off, contact
// [RULE8] attempts cleared after 10 calm minutes, on fault reset, at power-up
// [RULE9] only the listed twelve fault kinds may be auto-restarted
// [RULE10] each relay can be set to show a restart attempt in progress
// [RULE11] DC braking engages only once output reaches brake start frequency
// [RULE12] braking current percent is a fraction of drive rated current
// [RULE13] stop braking for its duration only if duration and current nonzero
// [RULE14] start braking only if duration and current nonzero, else run at once
// [RULE15] brake start below minimum frequency: brake at minimum frequency
// [RULE16] sensor vector mode: no DC braking, no brake stop, no timed coast
// [RULE17] stop mode 0 ramp, 1 coast, 2 DC brake, 3 coast with lockout
// [RULE18] ramp stop time is decel time times stop frequency over fmax
// [RULE19] coast: output off, no run until inhibit ends; sensorless searches
// [RULE20] brake stop: off, inhibit wait, brake stop time x10 x f over fmax
// [RULE21] timed coast: runs ignored until lockout from decel time and f ends
// [RULE22] undervoltage when bus below level for detect time; zero is instant
// [RULE23] a run command pre-magnetises the motor for the pre-excite time
// [RULE24] all durations are tick counters loaded when each phase begins; the 8 ms power-loss counter counts mclk cycles
// [RULE25] faults beat run commands; output held off while timers run

package dsrc_pkg;

	localparam int unsigned CLK_HZ    = 10_000_000;
	localparam int unsigned TICK_MS   = 10;
	localparam int unsigned TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned PLOSS_US  = 8000;
	localparam int unsigned PLOSS_CYC = CLK_HZ / 1_000_000 * PLOSS_US;
	localparam int unsigned CALM_MIN  = 10;

	// settings arrive in seconds, tenths and hundredths of a second
	localparam logic [19:0] CALM_TICKS = 20'(CALM_MIN * 60 * 1000 / TICK_MS);
	localparam logic [19:0] SEC_TICKS  = 20'(1000 / TICK_MS);
	localparam logic [19:0] DSEC_TICKS = 20'(100 / TICK_MS);
	localparam logic [19:0] DCB_SCALE  = 20'h0000a;
	localparam logic [22:0] PCT_FULL   = 23'h000064;

	localparam logic [1:0] STOP_RAMP  = 2'h0;
	localparam logic [1:0] STOP_COAST = 2'h1;
	localparam logic [1:0] STOP_DCB   = 2'h2;
	localparam logic [1:0] STOP_TIMED = 2'h3;

	localparam logic [2:0] CYC_CONT_LO = 3'h1;
	localparam logic [2:0] CYC_CONT_HI = 3'h3;
	localparam logic [2:0] CYC_NEW_LO  = 3'h4;
	localparam logic [2:0] CYC_NEW_HI  = 3'h6;

	localparam logic [1:0] CTL_SLV = 2'h2;
	localparam logic [1:0] CTL_SV  = 2'h3;

	typedef struct packed {
		logic run;
		logic fault_reset;
		logic power_ok;
	} dsrc_cmd_s;

	typedef struct packed {
		logic [2:0]  cycle_mode;
		logic        ploss_restart;
		logic [12:0] reset_time_s;
		logic [5:0]  inhibit_ds;
		logic [3:0]  attempt_limit;
		logic [13:0] dcb_freq;
		logic [6:0]  dcb_pct;
		logic [9:0]  stop_braking_duration;
		logic [9:0]  start_braking_cs;
		logic [1:0]  stop_mode;
		logic [1:0]  ctl_mode;
		logic [9:0]  uv_level;
		logic [6:0]  uv_time_cs;
		logic [9:0]  preex_cs;
		logic [15:0] decel_ds;
		logic [13:0] fmin;
		logic [13:0] fmax;
		logic [15:0] rated_amps;
		logic        relay_one_restart;
		logic        relay_two_restart;
	} dsrc_cfg_s;

	typedef struct packed {
		logic overcurrent_fault;
		logic ground_fault;
		logic fuse_open_fault;
		logic overvoltage_fault;
		logic input_phase_loss_fault;
		logic overheat_fault;
		logic motor_overload_fault;
		logic drive_overload_fault;
		logic over_torque_fault;
		logic under_torque_fault;
		logic output_phase_loss_fault;
		logic other_fault;
	} dsrc_flt_s;

	typedef enum logic [3:0] {
		ST_IDLE, ST_PREEX, ST_START_DCB, ST_SEARCH, ST_RUN,
		ST_DECEL, ST_STOP_DCB, ST_DCB_WAIT, ST_INHIBIT, ST_PWR_DIP,
		ST_FLT_INH, ST_FLT_WAIT, ST_TRIPPED
	} dsrc_st_e;

endpackage

// *** hdl/dsrc_sync.sv ***
// two-stage synchroniser for the operator command pins
// assumes the pins are asynchronous to mclk and change slowly

`timescale 1ns/10ps

module dsrc_sync (
	input  wire logic               mclk,
	input  wire logic               sys_rst,
	input  wire dsrc_pkg::dsrc_cmd_s pin,
	output dsrc_pkg::dsrc_cmd_s      synced
);
	import dsrc_pkg::*;

	typedef struct packed {
		dsrc_cmd_s meta;
		dsrc_cmd_s held;
	} dsrc_sync_s;

	dsrc_sync_s state;
	dsrc_sync_s next_state;

	always_comb begin
		next_state.meta = pin;
		next_state.held = state.meta;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign synced = state.held;

endmodule

// *** hdl/dsrc_ctrl.sv ***
// drive restart and stop control: start, stop, fault restart, DC braking
// assumes fault flags, frequency and bus voltage come from mclk logic;
// command pins are resynchronised here

`timescale 1ns/10ps

module dsrc_ctrl #(
	parameter int unsigned TICK_CYCLES  = dsrc_pkg::TICK_CYC,
	parameter int unsigned PLOSS_CYCLES = dsrc_pkg::PLOSS_CYC
) (
	input  wire logic                mclk,
	input  wire logic                sys_rst,
	input  wire dsrc_pkg::dsrc_cmd_s cmd_pin,
	input  wire dsrc_pkg::dsrc_cfg_s cfg,
	input  wire dsrc_pkg::dsrc_flt_s flt,
	input  wire logic [13:0]         fout,
	input  wire logic [9:0]          bus_volts,
	input  wire logic                search_done,
	output logic                     out_inhibit,
	output logic                     dc_brake_en,
	output logic [15:0]              dcb_amps,
	output logic                     preexcite_en,
	output logic                     decel_req,
	output logic [19:0]              decel_time,
	output logic                     speed_search_req,
	output logic                     restart_active,
	output logic                     fault_shown,
	output logic                     fault_contact,
	output logic                     undervoltage_fault,
	output logic                     relay_output_one,
	output logic                     relay_output_two,
	output logic                     cycle_restart,
	output logic                     cycle_resume
);
	import dsrc_pkg::*;

	////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		dsrc_st_e    st;
		logic [16:0] pre;
		logic [19:0] tmr;
		logic [19:0] calm;
		logic [19:0] dcb_time;
		logic [19:0] decel_time;
		logic [15:0] dcb_amps;
		logic [3:0]  att;
		logic [6:0]  uvc;
		logic [16:0] plc;
		logic        uv;
		logic        shown;
		logic        flt_ok;
		logic        search_pend;
		logic        restarting;
		logic        stopped;
		logic        step_new;
		logic        step_cont;
	} dsrc_ctrl_s;

	dsrc_ctrl_s state;
	dsrc_ctrl_s next_state;
	dsrc_cmd_s  cmd;

	dsrc_sync u_sync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.pin     (cmd_pin),
		.synced  (cmd)
	);

	// time scaled by frequency over fmax; fmax of zero gives zero time
	function automatic logic [19:0] dsrc_scale(
		input logic [19:0] t,
		input logic [13:0] f,
		input logic [13:0] fm
	);
		logic [33:0] p;
		logic [33:0] q;
		begin
			p = 34'(t) * 34'(f);
			q = (fm == 14'h0) ? 34'h0 : p / 34'(fm);
			return q[19:0];
		end
	endfunction

	// attempt limit beyond ten is treated as ten
	function automatic logic [3:0] ATT_LIMIT_CAP();
		return 4'ha;
	endfunction

	////////////////////////////////////////////////////////////////////////

	logic        tick;
	logic        tmr_done;
	logic        sv;
	logic        dcb_ok;
	logic [1:0]  mode;
	logic [13:0] brake_freq;
	logic [19:0] inh_ticks;
	logic [19:0] rst_ticks;
	logic [19:0] interval;
	logic [19:0] lock_ticks;
	logic        restartable;
	logic        ploss_trip;
	logic        motor_on;
	logic        fault_any;
	logic        below;

	always_comb begin
		tick     = (state.pre == 17'(TICK_CYCLES - 1));
		tmr_done = (state.tmr == 20'h0);
		sv       = (cfg.ctl_mode == CTL_SV);
		dcb_ok   = (cfg.dcb_pct != 7'h0) && !sv;                 // [RULE16]
		// in sensor vector mode, brake stop and timed coast fall back to a ramp stop
		mode = (sv && cfg.stop_mode[1]) ? STOP_RAMP : cfg.stop_mode; // [RULE16]
		brake_freq = (cfg.dcb_freq < cfg.fmin) ?
			cfg.fmin : cfg.dcb_freq;                                 // [RULE15]
		inh_ticks = 20'(cfg.inhibit_ds) * DSEC_TICKS;               // [RULE24]
		rst_ticks = 20'(cfg.reset_time_s) * SEC_TICKS;
		interval  = (rst_ticks > inh_ticks) ? rst_ticks : inh_ticks; // [RULE4]
		lock_ticks = dsrc_scale(20'(cfg.decel_ds) * DSEC_TICKS,
			fout, cfg.fmax);                                         // [RULE21]
		restartable = flt.overcurrent_fault | flt.ground_fault
			| flt.fuse_open_fault | flt.overvoltage_fault
			| flt.input_phase_loss_fault | flt.overheat_fault
			| flt.motor_overload_fault | flt.drive_overload_fault
			| flt.over_torque_fault | flt.under_torque_fault
			| flt.output_phase_loss_fault | state.uv;                // [RULE9]
		motor_on = (state.st == ST_PREEX) || (state.st == ST_START_DCB)
			|| (state.st == ST_SEARCH) || (state.st == ST_RUN)
			|| (state.st == ST_DECEL) || (state.st == ST_STOP_DCB);
		ploss_trip = motor_on && !cfg.ploss_restart
			&& (state.plc == 17'(PLOSS_CYCLES));                     // [RULE3]
		// bus sag is expected while riding through a dip
		fault_any = restartable || flt.other_fault || ploss_trip;
		if (state.st == ST_PWR_DIP && !(|flt)) begin
			fault_any = 1'b0;
		end
		below = (bus_volts < cfg.uv_level); // [RULE22]
	end

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_state = state;
		next_state.step_new  = 1'b0;
		next_state.step_cont = 1'b0;
		next_state.pre = tick ? 17'h0 : state.pre + 17'h1;
		if (tick && !tmr_done) begin
			next_state.tmr = state.tmr - 20'h1;                      // [RULE24]
		end

		// undervoltage qualification, zero time flags at once
		if (!below) begin
			next_state.uvc = 7'h0;
		end else if (tick && state.uvc != cfg.uv_time_cs) begin
			next_state.uvc = state.uvc + 7'h1;
		end
		next_state.uv = ploss_trip || (below && state.uvc >= cfg.uv_time_cs);

		// loss counter saturates at the limit
		if (cmd.power_ok) begin
			next_state.plc = 17'h0;
		end else if (state.plc != 17'(PLOSS_CYCLES)) begin
			next_state.plc = state.plc + 17'h1;
		end

		next_state.dcb_amps = 16'((23'(cfg.dcb_pct) * 23'(cfg.rated_amps))
			/ PCT_FULL);                                             // [RULE12]

		// calm running after a restart clears the attempt count
		if (state.st == ST_RUN && state.att != 4'h0) begin
			if (tick) begin
				next_state.calm = state.calm + 20'h1;
			end
			if (state.calm >= CALM_TICKS) begin
				next_state.att  = 4'h0;                              // [RULE8]
				next_state.calm = 20'h0;
			end
		end else if (state.st != ST_RUN) begin
			next_state.calm = 20'h0;
		end

		unique case (state.st)
			ST_IDLE: begin
				if (cmd.run) begin
					if (state.stopped) begin
						next_state.step_new = (cfg.cycle_mode >= CYC_NEW_LO)
							&& (cfg.cycle_mode <= CYC_NEW_HI);       // [RULE1]
						next_state.step_cont = (cfg.cycle_mode >= CYC_CONT_LO)
							&& (cfg.cycle_mode <= CYC_CONT_HI);      // [RULE2]
					end
					if (state.search_pend) begin
						next_state.st = ST_SEARCH;                   // [RULE19]
					end else begin
						next_state.st  = ST_PREEX;                   // [RULE23]
						next_state.tmr = 20'(cfg.preex_cs);
					end
				end
			end
			ST_PREEX: begin
				if (tmr_done) begin
					if (dcb_ok && cfg.start_braking_cs != 10'h0) begin
						next_state.st  = ST_START_DCB;               // [RULE14]
						next_state.tmr = 20'(cfg.start_braking_cs);
					end else begin
						next_state.st = ST_RUN;                      // [RULE14]
					end
				end
			end
			ST_START_DCB: begin
				if (tmr_done) begin
					next_state.st = ST_RUN;
				end
			end
			ST_SEARCH: begin
				if (search_done) begin
					next_state.st          = ST_RUN;
					next_state.search_pend = 1'b0;
					next_state.restarting  = 1'b0;
				end
			end
			ST_RUN: begin
				if (!cmd.power_ok && cfg.ploss_restart) begin
					next_state.st  = ST_PWR_DIP;                     // [RULE3]
					next_state.tmr = inh_ticks;
				end else if (!cmd.run) begin
					next_state.stopped = 1'b1;
					unique case (mode)                               // [RULE17]
						STOP_RAMP: begin
							next_state.st = ST_DECEL;
							next_state.decel_time = dsrc_scale(
								20'(cfg.decel_ds), fout, cfg.fmax);  // [RULE18]
						end
						STOP_COAST: begin
							next_state.st  = ST_INHIBIT;             // [RULE19]
							next_state.tmr = inh_ticks;
							next_state.search_pend =
								(cfg.ctl_mode == CTL_SLV);           // [RULE19]
						end
						STOP_DCB: begin
							next_state.st  = ST_DCB_WAIT;            // [RULE20]
							next_state.tmr = inh_ticks;
							next_state.dcb_time = dsrc_scale(
								20'(cfg.stop_braking_duration) * DCB_SCALE,
								fout, cfg.fmax);                     // [RULE20]
						end
						STOP_TIMED: begin
							next_state.st  = ST_INHIBIT;             // [RULE21]
							next_state.tmr = (lock_ticks > inh_ticks) ?
								lock_ticks : inh_ticks;              // [RULE21]
						end
					endcase
				end
			end
			ST_DECEL: begin
				if (cmd.run) begin
					next_state.st = ST_RUN;
				end else if (fout <= brake_freq) begin               // [RULE11]
					if (dcb_ok && cfg.stop_braking_duration != 10'h0) begin
						next_state.st  = ST_STOP_DCB;                // [RULE13]
						next_state.tmr = 20'(cfg.stop_braking_duration);
					end else begin
						next_state.st = ST_IDLE;
					end
				end
			end
			ST_STOP_DCB: begin
				if (tmr_done) begin
					next_state.st = ST_IDLE;
				end
			end
			ST_DCB_WAIT: begin
				if (tmr_done) begin
					if (dcb_ok && cfg.stop_braking_duration != 10'h0) begin
						next_state.st  = ST_STOP_DCB;                // [RULE13]
						next_state.tmr = state.dcb_time;
					end else begin
						next_state.st = ST_IDLE;
					end
				end
			end
			ST_INHIBIT: begin
				if (tmr_done) begin
					next_state.st = ST_IDLE;                         // [RULE25]
				end
			end
			ST_PWR_DIP: begin
				if (cmd.power_ok && tmr_done) begin
					next_state.st = ST_SEARCH;                       // [RULE3]
				end
			end
			ST_FLT_INH: begin
				if (tmr_done) begin
					next_state.shown = 1'b0;                         // [RULE6]
					if (state.flt_ok && cfg.ploss_restart
						&& state.att < cfg.attempt_limit
						&& state.att < ATT_LIMIT_CAP()) begin
						next_state.st  = ST_FLT_WAIT;                // [RULE4]
						next_state.tmr = interval - inh_ticks;
					end else begin
						next_state.st = ST_TRIPPED;                  // [RULE7]
					end
				end
			end
			ST_FLT_WAIT: begin
				if (tmr_done) begin
					next_state.att = state.att + 4'h1;               // [RULE7]
					next_state.st  = ST_SEARCH;                      // [RULE6]
				end
			end
			ST_TRIPPED: begin
				if (cmd.fault_reset) begin
					next_state.st = ST_IDLE;
				end
			end
		endcase

		// faults take precedence over run commands
		if (fault_any && state.st != ST_FLT_INH
			&& state.st != ST_TRIPPED) begin                         // [RULE25]
			next_state.st         = ST_FLT_INH;                      // [RULE5]
			next_state.tmr        = inh_ticks;
			next_state.shown      = 1'b1;
			next_state.flt_ok     = restartable && !flt.other_fault; // [RULE9]
			next_state.restarting = 1'b1;
			next_state.stopped    = 1'b1;
		end
		if (cmd.fault_reset) begin
			next_state.att = 4'h0;                                   // [RULE8]
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= '0;                                             // [RULE8]
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		out_inhibit = !motor_on;                                     // [RULE25]
		dc_brake_en = (state.st == ST_START_DCB)
			|| (state.st == ST_STOP_DCB);
		preexcite_en     = (state.st == ST_PREEX);
		decel_req        = (state.st == ST_DECEL);
		speed_search_req = (state.st == ST_SEARCH);
		restart_active   = state.restarting
			&& (state.st == ST_FLT_WAIT || state.st == ST_SEARCH);
		fault_contact = (state.st == ST_TRIPPED);                    // [RULE7]
		relay_output_one = cfg.relay_one_restart ?
			restart_active : fault_contact;                          // [RULE10]
		relay_output_two = cfg.relay_two_restart ?
			restart_active : fault_contact;                          // [RULE10]
	end

	assign dcb_amps           = state.dcb_amps;
	assign decel_time         = state.decel_time;
	assign fault_shown        = state.shown;
	assign undervoltage_fault = state.uv;
	assign cycle_restart      = state.step_new;
	assign cycle_resume       = state.step_cont;

endmodule

// *** testbench/dsrc_ctrl_assertions.sv ***
// checker for the restart and stop sequencer, bound into dsrc_ctrl
// assumes settings only change while the drive stands idle
`timescale 1ns/10ps
module dsrc_ctrl_assertions
	import dsrc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES  = 10,
	parameter int unsigned PLOSS_CYCLES = 8
) (
	input wire logic                mclk,
	input wire logic                sys_rst,
	input wire dsrc_pkg::dsrc_cfg_s cfg,
	input wire dsrc_pkg::dsrc_flt_s flt,
	input wire logic [13:0]         fout,
	input wire logic [9:0]          bus_volts,
	input wire logic                out_inhibit,
	input wire logic                dc_brake_en,
	input wire logic                preexcite_en,
	input wire logic                decel_req,
	input wire logic                restart_active,
	input wire logic                fault_shown,
	input wire logic                fault_contact,
	input wire logic                undervoltage_fault,
	input wire logic                relay_output_one,
	input wire logic                relay_output_two,
	input wire logic                cycle_restart,
	input wire logic                cycle_resume
);
	logic [13:0] brake_lim;
	logic [15:0] pre_cnt;
	logic        ran;
	int unsigned pre_lo;
	int unsigned pre_hi;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////
	assign brake_lim = (cfg.dcb_freq > cfg.fmin) ? cfg.dcb_freq : cfg.fmin;
	// the tick runs free, so a phase may lose up to one tick
	assign pre_lo = (cfg.preex_cs == 10'h000) ? 0 :
		(32'(cfg.preex_cs) - 1) * TICK_CYCLES;
	assign pre_hi = 32'(cfg.preex_cs) * TICK_CYCLES + 3;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			{ran, pre_cnt} <= 17'h00000;
		else
			{ran, pre_cnt} <= {ran | !out_inhibit,
				preexcite_en ? pre_cnt + 16'h0001 : 16'h0000};
	end

	////////////////////////////////////////////////////////////////////////
	a_fault_output_off: assert property (
		$rose(|flt) |-> ##[1:3] (out_inhibit && fault_shown))
		else $error("fault did not turn the output off");
	a_trip_holds_off: assert property (
		fault_contact |-> out_inhibit)
		else $error("fault contact with output on");
	a_sv_no_brake: assert property (
		cfg.ctl_mode == CTL_SV |-> !dc_brake_en)
		else $error("dc braking in sensor vector mode");
	a_brake_at_freq: assert property (
		$past(decel_req) && dc_brake_en |-> $past(fout) <= $past(brake_lim))
		else $error("stop braking above its start frequency");
	a_uv_instant: assert property (
		cfg.uv_time_cs == 7'h00 && bus_volts < cfg.uv_level && !out_inhibit
		|-> ##[1:3] undervoltage_fault)
		else $error("zero detect time did not flag undervoltage");
	a_new_cycle: assert property (
		$rose(preexcite_en) && ran && cfg.cycle_mode >= CYC_NEW_LO &&
		cfg.cycle_mode <= CYC_NEW_HI |-> cycle_restart && !cycle_resume)
		else $error("run did not restart the step cycle");
	a_cont_cycle: assert property (
		$rose(preexcite_en) && ran && cfg.cycle_mode >= CYC_CONT_LO &&
		cfg.cycle_mode <= CYC_CONT_HI |-> cycle_resume && !cycle_restart)
		else $error("run did not resume the step cycle");
	a_preex_length: assert property (
		$fell(preexcite_en) && !out_inhibit |->
		32'(pre_cnt) >= pre_lo && 32'(pre_cnt) <= pre_hi)
		else $error("pre-excitation length wrong");
	a_relay_restart: assert property (
		cfg.relay_one_restart |-> relay_output_one == restart_active)
		else $error("relay one does not follow restart");
	a_relay_fault: assert property (
		!cfg.relay_two_restart |-> relay_output_two == fault_contact)
		else $error("relay two does not follow fault contact");
endmodule

bind dsrc_ctrl dsrc_ctrl_assertions #(
	.TICK_CYCLES(TICK_CYCLES), .PLOSS_CYCLES(PLOSS_CYCLES)
) u_chk (
	.mclk, .sys_rst, .cfg, .flt, .fout, .bus_volts, .out_inhibit,
	.dc_brake_en, .preexcite_en, .decel_req, .restart_active,
	.fault_shown, .fault_contact, .undervoltage_fault,
	.relay_output_one, .relay_output_two, .cycle_restart, .cycle_resume
);

// *** testbench/dsrc_motor.sv ***
// partner model: power stage frequency and speed search answer
// assumes the sequencer outputs are registered on mclk
`timescale 1ns/10ps
module dsrc_motor #(
	parameter logic [13:0] F_RUN = 14'h01f4,
	parameter int unsigned SRCH  = 12
) (
	input  wire logic   mclk,
	input  wire logic   sys_rst,
	input  wire logic   out_inhibit,
	input  wire logic   decel_req,
	input  wire logic   speed_search_req,
	input  wire logic   slow,
	output logic [13:0] fout,
	output logic        search_done
);
	int cnt;

	// output off drops the frequency at once, so the sequencer must have
	// latched it at the stop command
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fout <= 14'h0000;
			cnt <= 0;
			search_done <= 1'b0;
		end else begin
			if (out_inhibit)
				fout <= 14'h0000;
			else if (decel_req)
				fout <= (fout > 14'h0014) ? fout - 14'h0014 : 14'h0000;
			else
				fout <= F_RUN;
			cnt <= speed_search_req ? cnt + 1 : 0;
			search_done <= speed_search_req && cnt == (slow ? 4 * SRCH : SRCH);
		end
	end
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the restart and stop sequencer with motor model
// assumes the design, its checker and dsrc_motor are compiled before it
`timescale 1ns/10ps
module testbench;
	import dsrc_pkg::*;
	localparam int unsigned TICK = 10;
	logic        mclk, sys_rst, slow, search_done, speed_search_req;
	logic        out_inhibit, dc_brake_en, preexcite_en, decel_req;
	logic        restart_active, fault_shown, fault_contact;
	logic        undervoltage_fault, relay_output_one, relay_output_two;
	logic        cycle_restart, cycle_resume;
	logic [13:0] fout;
	logic [15:0] dcb_amps;
	logic [9:0]  bus;
	dsrc_cmd_s   cmd;
	dsrc_cfg_s   cfg;
	dsrc_flt_s   flt;
	logic        s_brk, s_dec, s_pre, s_srch;
	int          miscompares, tests_run, n_new, n_cont, m;

	dsrc_ctrl #(.TICK_CYCLES(TICK), .PLOSS_CYCLES(8)) dut (
		.mclk, .sys_rst, .cmd_pin(cmd), .cfg, .flt, .fout,
		.bus_volts(bus), .search_done, .out_inhibit, .dc_brake_en,
		.dcb_amps, .preexcite_en, .decel_req, .decel_time(),
		.speed_search_req, .restart_active, .fault_shown,
		.fault_contact, .undervoltage_fault, .relay_output_one,
		.relay_output_two, .cycle_restart, .cycle_resume
	);
	dsrc_motor u_motor (
		.mclk, .sys_rst, .out_inhibit, .decel_req, .speed_search_req,
		.slow, .fout, .search_done
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// the whole sequence needs about 10000 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		miscompares++;
		close_out();
	end
	always @(posedge mclk) begin
		s_brk = s_brk | (dc_brake_en === 1'b1);
		s_dec = s_dec | (decel_req === 1'b1);
		s_pre = s_pre | (preexcite_en === 1'b1);
		s_srch = s_srch | (speed_search_req === 1'b1);
		n_new += (cycle_restart === 1'b1);
		n_cont += (cycle_resume === 1'b1);
	end

	////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic chk(input logic [19:0] got, input logic [19:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
			miscompares++;
		end
	endtask
	function automatic logic cond(input int k);
		case (k)
			0: return !out_inhibit && !preexcite_en && !dc_brake_en &&
				!decel_req && !speed_search_req;
			1: return fault_shown;
			2: return speed_search_req;
			3: return fault_contact;
			default: return undervoltage_fault;
		endcase
	endfunction
	task automatic wait_on(input int k, input string what);
		for (int i = 0; i < 2000 && cond(k) !== 1'b1; i++)
			cyc(1);
		chk(cond(k), 1, what);
	endtask
	task automatic clr();
		{s_brk, s_dec, s_pre, s_srch} = 4'h0;
		n_new = 0;
		n_cont = 0;
	endtask
	task automatic run_up();
		cmd.run = 1'b1;
		wait_on(0, "running");
	endtask
	task automatic hit(input int b);
		flt = dsrc_flt_s'(12'h800 >> b);
		cyc(3);
		flt = '0;
		wait_on(1, "fault shown");
		chk(out_inhibit, 1, "fault output off");
	endtask
	task automatic freset();
		cmd.fault_reset = 1'b1;
		cyc(4);
		cmd.fault_reset = 1'b0;
		cyc(2);
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		{cmd, flt, slow} = '0;
		cmd.power_ok = 1'b1;
		bus = 10'h12c;
		sys_rst = 1'b1;
		clr();
		cfg = '0;
		cfg.inhibit_ds = 6'h02;
		cfg.attempt_limit = 4'h1;
		cfg.dcb_freq = 14'h0032;
		cfg.dcb_pct = 7'h32;
		cfg.stop_braking_duration = 10'h005;
		cfg.uv_level = 10'h0c8;
		cfg.uv_time_cs = 7'h03;
		cfg.preex_cs = 10'h003;
		cfg.decel_ds = 16'h0004;
		cfg.fmin = 14'h000a;
		cfg.fmax = 14'h03e8;
		cfg.rated_amps = 16'h00c8;
		cfg.relay_one_restart = 1'b1;
		cyc(5);
		chk({out_inhibit, dc_brake_en, preexcite_en, fault_contact},
			4'h8, "reset outputs");
		cyc(1);
		sys_rst = 1'b0;
		cyc(3);
		chk(dcb_amps, 20'h00064, "brake current");
		// passes 0..3 walk the stop modes, pass 4 is sensor vector
		for (m = 0; m < 5; m++) begin
			cfg.cycle_mode = 3'(3 + m % 4);
			cfg.start_braking_cs = (m == 1) ? 10'h002 : 10'h000;
			cfg.stop_mode = (m == 4) ? STOP_DCB : 2'(m);
			cfg.ctl_mode = (m == 4) ? CTL_SV : 2'h0;
			clr();
			run_up();
			chk(n_cont, m == 4, "resume pulse");
			chk(n_new, m % 4 != 0, "restart pulse");
			chk(s_brk, m == 1, "start braking");
			clr();
			cmd.run = 1'b0;
			cyc(4);
			chk(out_inhibit, m > 0 && m < 4, "stop output off");
			chk(s_dec, m % 4 == 0, "ramp stop");
			if (m > 0 && m < 4) begin
				cmd.run = 1'b1;
				cyc(60);
				chk(s_pre, 0, "run refused");
				cmd.run = 1'b0;
			end
			cyc(900);
			chk(s_brk, m == 0 || m == 2, "stop braking");
		end
		cfg.ctl_mode = 2'h0;
		cfg.ploss_restart = 1'b1;
		for (m = 0; m < 11; m++) begin
			slow = 1'(m % 2);
			run_up();
			hit(m);
			wait_on(2, "restart search");
			chk(fault_shown, 0, "fault cleared");
			wait_on(0, "resumed");
			freset();
		end
		hit(4);
		wait_on(0, "resumed once");
		clr();
		hit(7);
		wait_on(3, "trip after limit");
		chk(s_srch, 0, "no retry past limit");
		cmd.run = 1'b0;
		freset();
		chk(fault_contact, 0, "contact cleared");
		run_up();
		clr();
		hit(11);
		wait_on(3, "other fault trip");
		chk(s_srch, 0, "no retry on other fault");
		cmd.run = 1'b0;
		freset();
		cfg.ploss_restart = 1'b0;
		run_up();
		bus = 10'h096;
		cyc(15);
		chk(undervoltage_fault, 0, "uv before detect time");
		cyc(30);
		chk(undervoltage_fault, 1, "uv after detect time");
		bus = 10'h12c;
		cmd.run = 1'b0;
		wait_on(3, "trip");
		freset();
		cfg.uv_time_cs = 7'h00;
		run_up();
		bus = 10'h096;
		cyc(3);
		chk(undervoltage_fault, 1, "uv at once");
		bus = 10'h12c;
		cmd.run = 1'b0;
		wait_on(3, "trip");
		freset();
		run_up();
		cmd.power_ok = 1'b0;
		wait_on(4, "power loss trip");
		cmd.power_ok = 1'b1;
		cmd.run = 1'b0;
		wait_on(3, "trip");
		freset();
		cfg.ploss_restart = 1'b1;
		run_up();
		cmd.power_ok = 1'b0;
		cyc(20);
		chk(out_inhibit, 1, "dip output off");
		chk(undervoltage_fault, 0, "dip without trip");
		cmd.power_ok = 1'b1;
		wait_on(0, "ride through");
		close_out();
	end
endmodule
